// ===== sbs_pkg.sv
package sbs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Settings register location and layout
  localparam logic [7:0] SETTINGS_ADDR = 8'h1C;
  localparam int BIT_PIN2_VALUE = 7;
  localparam int BIT_PIN1_VALUE = 6;
  localparam int BIT_ANY_ALARM = 5;
  localparam int BIT_POWER_ON = 4;
  localparam int BIT_TIMEOUT_EN = 3;
  localparam int BIT_BYTE_COUNT = 2;
  localparam int BIT_NO_SKIP = 1;
  localparam int BIT_FAST_FILTER = 0;
  localparam logic [7:0] SETTINGS_RESET = 8'h10;
  // Bits stored straight from a host write; alarm and power-on are handled apart
  localparam logic [7:0] SETTINGS_WRITE_MASK = 8'hCF;
  localparam logic [7:0] IDLE_READ_BYTE = 8'h00;
  localparam logic [7:0] FILL_BYTE = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel address blocks, two addresses per channel, four channels
  localparam int CHAN_COUNT = 4;
  localparam logic [7:0] CHAN_FIRST = 8'h13;
  localparam logic [7:0] CHAN_LAST = 8'h1A;
  localparam int SKIP_MAX = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_NS = 40;
  localparam int TIMEOUT_MS = 25;
  localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int SPIKE_STD_NS = 50;
  localparam int SPIKE_FAST_NS = 10;
  localparam int SPIKE_STD_CYC = (SPIKE_STD_NS + CLK_NS - 1) / CLK_NS < 1 ? 1 :
                                 (SPIKE_STD_NS + CLK_NS - 1) / CLK_NS;
  localparam int SPIKE_FAST_CYC = (SPIKE_FAST_NS + CLK_NS - 1) / CLK_NS < 1 ? 1 :
                                  (SPIKE_FAST_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    TMO_IDLE = 2'b00,
    TMO_COUNT = 2'b01,
    TMO_EXPIRED = 2'b11
  } sbs_tmo_state_type;

  function automatic logic in_chan_block(input logic [7:0] addr);
    in_chan_block = (addr >= CHAN_FIRST) && (addr <= CHAN_LAST);
  endfunction

  function automatic logic [1:0] chan_of(input logic [7:0] addr);
    logic [7:0] rel;
    rel = addr - CHAN_FIRST;
    chan_of = rel[1:0];
  endfunction

endpackage

// ===== sbs_ptr_if.sv
`timescale 1ns/100ps
interface sbs_ptr_if;
  logic [7:0] cur;
  logic [3:0] chan_active;
  logic no_skip;
  logic [7:0] next;
  logic fill;

  modport owner (
    output cur,
    output chan_active,
    output no_skip,
    input next,
    input fill
  );

  modport stepper (
    input cur,
    input chan_active,
    input no_skip,
    output next,
    output fill
  );
endinterface

// ===== sbs_spike_filter.sv
`timescale 1ns/100ps
module sbs_spike_filter #(
  parameter int LINES = 2,
  parameter int CNT_W = 4,
  parameter int STD_CYC = sbs_pkg::SPIKE_STD_CYC,
  parameter int FAST_CYC = sbs_pkg::SPIKE_FAST_CYC
) (
  input wire logic mclk, // Device clock
  input wire logic rstn, // Async reset, active low
  input wire logic [LINES-1:0] raw, // Bus lines as sampled
  input wire logic fast, // Narrow filter for high-speed bus
  output logic [LINES-1:0] clean // Filtered bus lines
);

  typedef struct packed {
    logic [LINES-1:0] lvl;
    logic [LINES-1:0][CNT_W-1:0] cnt;
  } sbs_filt_type;

  sbs_filt_type q;
  sbs_filt_type d;
  logic [CNT_W-1:0] limit;

  ////////////////////////////////////////////////////////////////////////////
  // A new level is accepted only once it has held for the limit
  always_comb
  begin
    d = q;
    limit = fast ? CNT_W'(FAST_CYC) : CNT_W'(STD_CYC); // [R11]
    for (int i = 0; i < LINES; i++)
    begin
      if (raw[i] == q.lvl[i])
      begin
        d.cnt[i] = '0;
      end
      else if (q.cnt[i] + CNT_W'(1) >= limit)
      begin
        d.lvl[i] = raw[i];
        d.cnt[i] = '0;
      end
      else
      begin
        d.cnt[i] = q.cnt[i] + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      q <= '{lvl: '1, cnt: '0};
    else
      q <= d;
  end

  assign clean = q.lvl;

endmodule

// ===== sbs_ptr_step.sv
`timescale 1ns/100ps
module sbs_ptr_step (
  sbs_ptr_if.stepper p // Pointer stepping port
);

  ////////////////////////////////////////////////////////////////////////////
  // Next pointer: up to four inactive channel addresses in a row are passed over unless told not to
  always_comb
  begin
    logic [7:0] a;
    logic stop;
    a = p.cur + 8'h01;
    stop = 1'b0;
    for (int i = 0; i < sbs_pkg::SKIP_MAX; i++)
    begin
      if (!stop && !p.no_skip && sbs_pkg::in_chan_block(a)
          && !p.chan_active[sbs_pkg::chan_of(a)]) // [R9]
        a = a + 8'h01;
      else
        stop = 1'b1;
    end
    p.next = a; // [R10]
  end

  // A disabled channel location reached by stepping reads as all ones
  assign p.fill = sbs_pkg::in_chan_block(p.cur) && !p.chan_active[sbs_pkg::chan_of(p.cur)]; // [R10]

endmodule

// ===== sbs_settings.sv
// What this block does
// R1: Pin 2 output low unless bit 7 set
// R2: Pin 1 output low unless bit 6 set
// R3: Any enabled non-conversion alert sets bit 5
// R4: Bit 5 clears once its causing alert clears
// R5: Power-on bit 4 resets to 1, host clears
// R6: Only internal power-on reset sets bit 4
// R7: Bit 3 enables bus time-out, default off
// R8: Bit 2 adds byte count to block reads
// R9: Bit 1 low: pointer skips inactive channels
// R10: Bit 1 high: no skip, inactive reads FF
// R11: Bit 0 narrows spike filter for 3.4 MHz
// R12: Settings act immediately, no refresh needed
// R13: Host clears bit 4 then polls it
`timescale 1ns/100ps
module sbs_settings #(
  parameter int ALERT_W = 8,
  parameter int TIMEOUT_CYCLES = sbs_pkg::TIMEOUT_CYCLES
) (
  input wire logic mclk, // Device clock, 25 MHz
  input wire logic rstn, // Power cycle reset, active low
  input wire logic power_down_pin_n, // Power-down pin, low forces internal reset
  input wire logic scl_raw, // Bus clock line
  input wire logic sda_raw, // Bus data line
  output logic scl_clean, // Filtered bus clock
  output logic sda_clean, // Filtered bus data
  input wire logic ptr_set, // Pulse: load register pointer
  input wire logic [7:0] ptr_value, // Pointer value to load
  input wire logic reg_wr, // Pulse: write byte at pointer
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_rd, // Pulse: read byte at pointer
  output logic [7:0] reg_rdata, // Read data
  output logic reg_rvalid, // Pulse: read data valid
  output logic [7:0] reg_ptr, // Current register pointer
  input wire logic [3:0] chan_active, // Channel enables
  input wire logic [ALERT_W-1:0] alert_cause, // Live alert causes, excluding conversion done
  input wire logic [ALERT_W-1:0] alert_enable, // Alert function enables
  input wire logic pin1_gpio_out, // First multipurpose pin is a GPIO output
  input wire logic pin2_gpio_out, // Second multipurpose pin is a GPIO output
  output logic pin1_o, // First pin drive level
  output logic pin1_oe, // First pin drive enable
  output logic pin2_o, // Second pin drive level
  output logic pin2_oe, // Second pin drive enable
  output logic any_alarm, // Summary alarm flag
  output logic bus_timeout_en, // Time-out feature active
  output logic bus_timeout, // Pulse: bus clock held low too long
  output logic byte_count_en, // Prefix block reads with byte count
  output logic fast_bus_filter_select // High-speed filter in use
);

  localparam int TMO_W = $clog2(TIMEOUT_CYCLES + 1);

  typedef struct packed {
    logic [7:0] settings;
    logic [7:0] ptr;
    logic [7:0] rdata;
    logic rvalid;
    logic pin1_oe;
    logic pin2_oe;
    sbs_pkg::sbs_tmo_state_type tmo;
    logic [TMO_W-1:0] tmo_cnt;
    logic tmo_pulse;
  } sbs_state_type;

  localparam sbs_state_type RESET_STATE = '{
    settings: sbs_pkg::SETTINGS_RESET,
    ptr: 8'h00,
    rdata: 8'h00,
    rvalid: 1'b0,
    pin1_oe: 1'b1,
    pin2_oe: 1'b1,
    tmo: sbs_pkg::TMO_IDLE,
    tmo_cnt: '0,
    tmo_pulse: 1'b0
  };

  sbs_state_type q;
  sbs_state_type d;
  logic [1:0] clean;
  logic [7:0] wr_merge;

  sbs_ptr_if ptr_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // Bus input spike filter
  sbs_spike_filter #(
    .LINES(2),
    .CNT_W(4),
    .STD_CYC(sbs_pkg::SPIKE_STD_CYC),
    .FAST_CYC(sbs_pkg::SPIKE_FAST_CYC)
  ) u_filter (
    .mclk(mclk),
    .rstn(rstn),
    .raw({sda_raw, scl_raw}),
    .fast(q.settings[sbs_pkg::BIT_FAST_FILTER]), // [R11]
    .clean(clean)
  );

  assign scl_clean = clean[0];
  assign sda_clean = clean[1];

  ////////////////////////////////////////////////////////////////////////////
  // Pointer stepping
  assign ptr_bus.cur = q.ptr;
  assign ptr_bus.chan_active = chan_active;
  assign ptr_bus.no_skip = q.settings[sbs_pkg::BIT_NO_SKIP]; // [R9] [R10]

  sbs_ptr_step u_step (
    .p(ptr_bus.stepper)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write merge: alarm bit is not host writable, power-on bit only clears
  always_comb
  begin
    wr_merge = (q.settings & ~sbs_pkg::SETTINGS_WRITE_MASK) | (reg_wdata & sbs_pkg::SETTINGS_WRITE_MASK);
    if (!reg_wdata[sbs_pkg::BIT_POWER_ON])
      wr_merge[sbs_pkg::BIT_POWER_ON] = 1'b0; // [R5]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    d = q;
    d.rvalid = 1'b0;
    d.tmo_pulse = 1'b0;

    // Alarm follows the enabled causes, so it drops once every cause is cleared or disabled
    d.settings[sbs_pkg::BIT_ANY_ALARM] = |(alert_cause & alert_enable); // [R3] [R4]

    // Written fields land in the register on the write edge and drive outputs from that same edge
    if (reg_wr && q.ptr == sbs_pkg::SETTINGS_ADDR)
    begin
      d.settings[7:6] = wr_merge[7:6]; // [R12]
      d.settings[4:0] = wr_merge[4:0]; // [R12]
    end

    if (reg_rd)
    begin
      d.rvalid = 1'b1;
      if (q.ptr == sbs_pkg::SETTINGS_ADDR)
        d.rdata = q.settings;
      else if (ptr_bus.fill)
        d.rdata = sbs_pkg::FILL_BYTE; // [R10]
      else
        d.rdata = sbs_pkg::IDLE_READ_BYTE;
    end

    // Load wins over a step; each data byte steps the pointer
    if (ptr_set)
      d.ptr = ptr_value;
    else if (reg_wr || reg_rd)
      d.ptr = ptr_bus.next; // [R9] [R10]

    // Open-drain pins: released for the pull-up when the bit is 1
    d.pin1_oe = pin1_gpio_out && !d.settings[sbs_pkg::BIT_PIN1_VALUE]; // [R2]
    d.pin2_oe = pin2_gpio_out && !d.settings[sbs_pkg::BIT_PIN2_VALUE]; // [R1]

    // Bus time-out watches the filtered clock line held low
    case (q.tmo)
      sbs_pkg::TMO_IDLE:
      begin
        d.tmo_cnt = '0;
        if (q.settings[sbs_pkg::BIT_TIMEOUT_EN] && !clean[0]) // [R7]
          d.tmo = sbs_pkg::TMO_COUNT;
      end
      sbs_pkg::TMO_COUNT:
      begin
        if (!q.settings[sbs_pkg::BIT_TIMEOUT_EN] || clean[0]) // [R7]
        begin
          d.tmo = sbs_pkg::TMO_IDLE;
          d.tmo_cnt = '0;
        end
        else if (q.tmo_cnt >= TMO_W'(TIMEOUT_CYCLES - 1))
        begin
          d.tmo = sbs_pkg::TMO_EXPIRED;
          d.tmo_pulse = 1'b1;
        end
        else
        begin
          d.tmo_cnt = q.tmo_cnt + TMO_W'(1);
        end
      end
      sbs_pkg::TMO_EXPIRED:
      begin
        // One pulse per stuck period; rearm once the clock line is released
        if (clean[0] || !q.settings[sbs_pkg::BIT_TIMEOUT_EN])
          d.tmo = sbs_pkg::TMO_IDLE;
      end
      default:
      begin
        d.tmo = sbs_pkg::TMO_IDLE;
        d.tmo_cnt = '0;
      end
    endcase

    // Power-down pin low is an internal power-on reset of all state except the spike filter
    if (!power_down_pin_n)
      d = RESET_STATE; // [R6]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Only the power-on paths restore the power-on bit to 1
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      q <= RESET_STATE; // [R5] [R6]
    else
      q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign pin1_o = 1'b0;
  assign pin2_o = 1'b0;
  assign pin1_oe = q.pin1_oe;
  assign pin2_oe = q.pin2_oe;
  assign any_alarm = q.settings[sbs_pkg::BIT_ANY_ALARM];
  assign bus_timeout_en = q.settings[sbs_pkg::BIT_TIMEOUT_EN]; // [R7]
  assign bus_timeout = q.tmo_pulse;
  assign byte_count_en = q.settings[sbs_pkg::BIT_BYTE_COUNT]; // [R8]
  assign fast_bus_filter_select = q.settings[sbs_pkg::BIT_FAST_FILTER]; // [R11]
  assign reg_rdata = q.rdata;
  assign reg_rvalid = q.rvalid;
  assign reg_ptr = q.ptr;

endmodule

// ===== sbs_settings_sva.sv
`timescale 1ns/100ps
module sbs_settings_sva #(
  parameter int ALERT_W = 8
) (
  input wire logic mclk, // Device clock
  input wire logic rstn, // Reset, active low
  input wire logic power_down_pin_n, // Internal reset request
  input wire logic scl_raw, // Raw bus clock
  input wire logic scl_clean, // Filtered bus clock
  input wire logic reg_rd, // Read pulse
  input wire logic reg_rvalid, // Read valid
  input wire logic [ALERT_W-1:0] alert_cause, // Alert causes
  input wire logic [ALERT_W-1:0] alert_enable, // Alert enables
  input wire logic pin1_gpio_out, // Pin 1 is output
  input wire logic pin2_gpio_out, // Pin 2 is output
  input wire logic pin1_o, // Pin 1 level
  input wire logic pin2_o, // Pin 2 level
  input wire logic pin1_oe, // Pin 1 enable
  input wire logic pin2_oe, // Pin 2 enable
  input wire logic any_alarm, // Summary alarm
  input wire logic bus_timeout_en, // Time-out on
  input wire logic bus_timeout, // Time-out pulse
  input wire logic fast_bus_filter_select // Fast filter
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  sequence rd_s;
    reg_rd && power_down_pin_n;
  endsequence
  sequence live_s;
    power_down_pin_n && |(alert_cause & alert_enable);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  rd_answer_a: assert property (rd_s |=> reg_rvalid) else $error("read not answered");
  rd_cause_a: assert property (reg_rvalid |-> $past(reg_rd)) else $error("valid without read");
  alarm_set_a: assert property (live_s |=> any_alarm) else $error("alarm not set");
  alarm_clear_a: assert property (!(|(alert_cause & alert_enable)) |=> !any_alarm) else $error("alarm stuck");
  pin1_idle_a: assert property (power_down_pin_n && !pin1_gpio_out |=> !pin1_oe) else $error("pin 1 driven");
  pin2_idle_a: assert property (power_down_pin_n && !pin2_gpio_out |=> !pin2_oe) else $error("pin 2 driven");
  pins_drain_a: assert property (!pin1_o && !pin2_o) else $error("pin drives high");
  tmo_cause_a: assert property (bus_timeout |-> $past(bus_timeout_en) && !$past(scl_clean))
    else $error("time-out without cause");
  tmo_pulse_a: assert property (bus_timeout |=> !bus_timeout) else $error("time-out not a pulse");
  // Standard filter needs two samples, so the first one must not pass
  filter_std_a: assert property (!fast_bus_filter_select && $changed(scl_raw) |=> $stable(scl_clean))
    else $error("spike passed filter");
endmodule

// ===== sbs_bus_host.sv
`timescale 1ns/100ps
module sbs_bus_host (
  output logic scl_raw, // Bus clock on the wire
  output logic sda_raw // Bus data on the wire
);
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  // Open drain: a released line goes to the pull-up level
  assign scl_raw = ~scl_low;
  assign sda_raw = ~sda_low;
endmodule

// ===== sbs_settings_tb.sv
`timescale 1ns/100ps
module sbs_settings_tb;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic pd_n = 1'b1;
  logic ptr_set = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, p1g = 1'b1, p2g = 1'b1;
  logic [7:0] ptr_value = 8'h00, reg_wdata = 8'h00, cause = 8'h00, en = 8'hFF;
  logic [3:0] chan = 4'hF;
  logic scl, sda, scl_c, sda_c, rvalid, p1o, p1oe, p2o, p2oe, alarm, tmo_en, tmo, bc_en, fast;
  logic [7:0] rdata, ptr, x, rnd = 8'h4E;
  logic [7:0] exp_q[$];
  int num_errors = 0, n_checks = 0, cyc = 0;
  sbs_settings #(.TIMEOUT_CYCLES(20)) uut (.mclk(mclk), .rstn(rstn), .power_down_pin_n(pd_n),
    .scl_raw(scl), .sda_raw(sda), .scl_clean(scl_c), .sda_clean(sda_c), .ptr_set(ptr_set),
    .ptr_value(ptr_value), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .reg_ptr(ptr), .chan_active(chan), .alert_cause(cause), .alert_enable(en),
    .pin1_gpio_out(p1g), .pin2_gpio_out(p2g), .pin1_o(p1o), .pin1_oe(p1oe), .pin2_o(p2o), .pin2_oe(p2oe),
    .any_alarm(alarm), .bus_timeout_en(tmo_en), .bus_timeout(tmo), .byte_count_en(bc_en),
    .fast_bus_filter_select(fast));
  sbs_bus_host host (.scl_raw(scl), .sda_raw(sda));
  initial forever #20 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask
  // Each write or read ends one idle cycle later so strobes are never re-raised in one step
  task automatic ld(input logic [7:0] a);
    ptr_set = 1'b1;
    ptr_value = a;
    tick;
    ptr_set = 1'b0;
  endtask
  task automatic set(input logic [7:0] a, input logic [7:0] d);
    ld(a);
    reg_wr = 1'b1;
    reg_wdata = d;
    tick;
    reg_wr = 1'b0;
    tick;
  endtask
  task automatic rd(input logic [7:0] e);
    reg_rd = 1'b1;
    exp_q.push_back(e);
    tick;
    reg_rd = 1'b0;
    tick;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      num_errors++;
      test_done;
    end
    if (rvalid === 1'b1)
      cmp("reg_rdata", exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX, rdata);
  end
  initial
  begin
    repeat (3) @(posedge mclk);
    #1 rstn = 1'b1;
    tick;
    cmp("timeout_en", 8'h00, {7'h00, tmo_en});
    cmp("byte_count_en", 8'h00, {7'h00, bc_en});
    cmp("fast_filter", 8'h00, {7'h00, fast});
    ld(8'h1C);
    rd(8'h10);
    set(8'h1C, 8'h00);
    ld(8'h1C);
    rd(8'h00);
    set(8'h1C, 8'hFF);
    ld(8'h1C);
    rd(8'hCF);
    cmp("enables", 8'h07, {5'h00, tmo_en, bc_en, fast});
    cmp("pin_oe", 8'h00, {6'h00, p2oe, p1oe});
    repeat (6)
    begin
      rnd = lfsr(rnd);
      p1g = rnd[2];
      p2g = rnd[3];
      set(8'h1C, rnd);
      ld(8'h1C);
      rd(rnd & 8'hCF);
      cmp("pin1_oe", {7'h00, p1g & ~rnd[6]}, {7'h00, p1oe});
      cmp("pin2_oe", {7'h00, p2g & ~rnd[7]}, {7'h00, p2oe});
    end
    set(8'h1C, 8'h00);
    cause = rnd | 8'h01;
    en = rnd | 8'h01;
    ld(8'h1C);
    rd(8'h20);
    cmp("any_alarm", 8'h01, {7'h00, alarm});
    en = ~cause;
    ld(8'h1C);
    rd(8'h00);
    cmp("any_alarm", 8'h00, {7'h00, alarm});
    pd_n = 1'b0;
    tick;
    pd_n = 1'b1;
    ld(8'h1C);
    rd(8'h10);
    chan = 4'h1;
    set(8'h1C, 8'h00);
    ld(8'h13);
    rd(8'h00);
    cmp("reg_ptr", 8'h17, ptr);
    set(8'h1C, 8'h02);
    ld(8'h13);
    rd(8'h00);
    cmp("reg_ptr", 8'h14, ptr);
    rd(8'hFF);
    set(8'h1C, 8'h08);
    host.scl_low = 1'b1;
    x = 8'h00;
    repeat (40)
    begin
      tick;
      x = x + {7'h00, tmo};
    end
    host.scl_low = 1'b0;
    cmp("timeout_pulses", 8'h01, x);
    for (int i = 0; i < 2; i++)
    begin
      set(8'h1C, i[7:0]);
      host.sda_low = 1'b1;
      tick;
      host.sda_low = 1'b0;
      x = 8'h01;
      repeat (4)
      begin
        x = x & {7'h00, sda_c};
        tick;
      end
      cmp("sda_clean", i ? 8'h00 : 8'h01, x);
    end
    test_done;
  end
endmodule
bind sbs_settings sbs_settings_sva #(.ALERT_W(ALERT_W)) chk (.mclk(mclk), .rstn(rstn),
  .power_down_pin_n(power_down_pin_n), .scl_raw(scl_raw), .scl_clean(scl_clean), .reg_rd(reg_rd),
  .reg_rvalid(reg_rvalid), .alert_cause(alert_cause), .alert_enable(alert_enable),
  .pin1_gpio_out(pin1_gpio_out), .pin2_gpio_out(pin2_gpio_out), .pin1_o(pin1_o), .pin2_o(pin2_o),
  .pin1_oe(pin1_oe), .pin2_oe(pin2_oe), .any_alarm(any_alarm), .bus_timeout_en(bus_timeout_en),
  .bus_timeout(bus_timeout), .fast_bus_filter_select(fast_bus_filter_select));
